// ===== csf_pkg.sv
// Constants, carriers and decode helpers for the CPU status flag block
package csf_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int CSF_ADDR_W = 8;
   localparam logic [7:0] CSF_OFS_STATUS = 8'h40;
   localparam logic [7:0] CSF_OFS_CORE_CTRL = 8'h44;
   localparam logic [7:0] CSF_OFS_EVT_STAT = 8'h48;
   localparam logic [7:0] CSF_OFS_EVT_MASK = 8'h4C;

   // ----------------------------------------------------------------
   // Status word field positions
   // ----------------------------------------------------------------
   localparam int CSF_BIT_OVF_A = 15;
   localparam int CSF_BIT_OVF_B = 14;
   localparam int CSF_BIT_SAT_A = 13;
   localparam int CSF_BIT_SAT_B = 12;
   localparam int CSF_BIT_OVF_AB = 11;
   localparam int CSF_BIT_SAT_AB = 10;
   localparam int CSF_BIT_LOOP = 9;
   localparam int CSF_BIT_DC = 8;
   localparam int CSF_BIT_IPL_LO = 5;
   localparam int CSF_BIT_RA = 4;

   // ----------------------------------------------------------------
   // Core control word
   // ----------------------------------------------------------------
   localparam logic [15:0] CSF_CORE_RESET = 16'h0020;
   localparam logic [15:0] CSF_CORE_IMPL = 16'h1FFF;
   localparam int CSF_BIT_IPL_MSB = 3;

   // ----------------------------------------------------------------
   // Event bits, bus answers
   // ----------------------------------------------------------------
   localparam int CSF_EVT_N = 4;
   localparam int CSF_EVT_OVF_A = 0;
   localparam int CSF_EVT_OVF_B = 1;
   localparam int CSF_EVT_SAT_A = 2;
   localparam int CSF_EVT_SAT_B = 3;
   localparam logic [1:0] CSF_RESP_OKAY = 2'b00;
   localparam logic [1:0] CSF_RESP_SLVERR = 2'b10;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ovf_a;
      logic ovf_b;
      logic sat_a;
      logic sat_b;
   } csf_acc_type;

   typedef struct packed {
      logic valid;
      logic byte_op;
      logic [15:0] op_a;
      logic [15:0] op_b;
      logic carry_in;
      logic [4:0] flags;
   } csf_alu_type;

   typedef struct packed {
      logic fire;
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } csf_wr_type;

   typedef struct packed {
      logic ovf_a;
      logic ovf_b;
      logic sat_a;
      logic sat_b;
      logic loop;
      logic dc;
      logic [2:0] ipl;
      logic [4:0] flags;
   } csf_sr_type;

   localparam csf_sr_type CSF_SR_RESET = '0;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic csf_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs);
      csf_hit = (addr[7:2] == ofs[7:2]);
   endfunction : csf_hit

   function automatic logic [15:0] csf_sr_pack(input csf_sr_type sr);
      csf_sr_pack = {sr.ovf_a, sr.ovf_b, sr.sat_a, sr.sat_b,
                     sr.ovf_a | sr.ovf_b, sr.sat_a | sr.sat_b,
                     sr.loop, sr.dc, sr.ipl, sr.flags};
   endfunction : csf_sr_pack

endpackage : csf_pkg

// ===== csf_axil_slave.sv
// AXI4-Lite slave front end: turns bus traffic into a write strobe and a read address
`timescale 1ns/10ps
module csf_axil_slave
   import csf_pkg::*;
(
   input wire logic i_clk,                  // Core clock
   input wire logic i_rst_n,                // Sync reset, active low
   input wire logic [7:0] i_s_axi_awaddr,   // Write address
   input wire logic i_s_axi_awvalid,        // Write address valid
   output logic o_s_axi_awready,            // Write address ready
   input wire logic [31:0] i_s_axi_wdata,   // Write data
   input wire logic [3:0] i_s_axi_wstrb,    // Write byte strobes
   input wire logic i_s_axi_wvalid,         // Write data valid
   output logic o_s_axi_wready,             // Write data ready
   output logic [1:0] o_s_axi_bresp,        // Write response
   output logic o_s_axi_bvalid,             // Write response valid
   input wire logic i_s_axi_bready,         // Write response ready
   input wire logic [7:0] i_s_axi_araddr,   // Read address
   input wire logic i_s_axi_arvalid,        // Read address valid
   output logic o_s_axi_arready,            // Read address ready
   output logic [31:0] o_s_axi_rdata,       // Read data
   output logic [1:0] o_s_axi_rresp,        // Read response
   output logic o_s_axi_rvalid,             // Read data valid
   input wire logic i_s_axi_rready,         // Read data ready
   output csf_wr_type o_wr,                 // Write strobe to registers
   input wire logic i_wr_ok,                // Write address is mapped
   output logic [7:0] o_rd_addr,            // Read address to decode
   input wire logic [31:0] i_rd_data,       // Decoded read data
   input wire logic i_rd_ok                 // Read address is mapped
);

   logic aw_held_reg, aw_held_next;
   logic w_held_reg, w_held_next;
   logic [7:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic fire;

   assign o_s_axi_awready = !aw_held_reg;
   assign o_s_axi_wready = !w_held_reg;
   assign o_s_axi_arready = !rvalid_reg;
   // One write in flight: a new pair waits until the response is taken
   assign fire = aw_held_reg && w_held_reg && !bvalid_reg;
   assign o_wr = '{fire: fire, addr: awaddr_reg, data: wdata_reg,
                   strb: wstrb_reg};
   assign o_rd_addr = i_s_axi_araddr;
   assign o_s_axi_bvalid = bvalid_reg;
   assign o_s_axi_bresp = bresp_reg;
   assign o_s_axi_rvalid = rvalid_reg;
   assign o_s_axi_rdata = rdata_reg;
   assign o_s_axi_rresp = rresp_reg;

   always_comb begin
      aw_held_next = aw_held_reg;
      w_held_next = w_held_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (i_s_axi_awvalid && !aw_held_reg) begin
         aw_held_next = 1'b1;
         awaddr_next = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && !w_held_reg) begin
         w_held_next = 1'b1;
         wdata_next = i_s_axi_wdata;
         wstrb_next = i_s_axi_wstrb;
      end
      if (bvalid_reg && i_s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (fire) begin
         aw_held_next = 1'b0;
         w_held_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = i_wr_ok ? CSF_RESP_OKAY : CSF_RESP_SLVERR;
      end
      if (rvalid_reg && i_s_axi_rready) begin
         rvalid_next = 1'b0;
      end
      if (i_s_axi_arvalid && !rvalid_reg) begin
         rvalid_next = 1'b1;
         rdata_next = i_rd_data;
         rresp_next = i_rd_ok ? CSF_RESP_OKAY : CSF_RESP_SLVERR;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= CSF_RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= CSF_RESP_OKAY;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

endmodule : csf_axil_slave

// ===== csf_irq.sv
// Sticky event status, mask and interrupt output
`timescale 1ns/10ps
module csf_irq
   import csf_pkg::*;
#(
   parameter int N = CSF_EVT_N
)(
   input wire logic i_clk,              // Core clock
   input wire logic i_rst_n,            // Sync reset, active low
   input wire logic [N-1:0] i_evt,      // Event pulses
   input wire logic i_wr_stat,          // Write-one-to-clear strobe
   input wire logic i_wr_mask,          // Mask write strobe
   input wire logic [N-1:0] i_wdata,    // Write data
   output logic [N-1:0] o_stat,         // Sticky status
   output logic [N-1:0] o_mask,         // Enable mask
   output logic o_irq                   // Level interrupt
);

   logic [N-1:0] stat_reg, stat_next;
   logic [N-1:0] mask_reg, mask_next;

   // Set wins over a clear in the same cycle
   for (genvar g = 0; g < N; g++) begin : g_bit
      always_comb begin
         stat_next[g] = i_evt[g] ||
                        (stat_reg[g] && !(i_wr_stat && i_wdata[g]));
      end
   end

   always_comb begin
      mask_next = i_wr_mask ? i_wdata : mask_reg;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         stat_reg <= '0;
         mask_reg <= '0;
      end else begin
         stat_reg <= stat_next;
         mask_reg <= mask_next;
      end
   end

   assign o_stat = stat_reg;
   assign o_mask = mask_reg;
   assign o_irq = |(stat_reg & mask_reg);

endmodule : csf_irq

// ===== csf_status_top.sv
// CPU status word and core control word with AXI4-Lite access
//
// Contract
// - Accumulator overflow flags: read-only, bits 15/14
// - Half carry from bit 3 or bit 7
// - Priority bits read-only while nesting disabled; core control bit 3 (priority level MSB) stays writable
// - Unimplemented bits read zero, ignore writes
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module csf_status_top
   import csf_pkg::*;
(
   input wire logic i_clk,                  // Core clock, 100 MHz
   input wire logic i_rst_n,                // Sync reset, active low
   input wire logic [7:0] i_s_axi_awaddr,   // Write address
   input wire logic i_s_axi_awvalid,        // Write address valid
   output logic o_s_axi_awready,            // Write address ready
   input wire logic [31:0] i_s_axi_wdata,   // Write data
   input wire logic [3:0] i_s_axi_wstrb,    // Write byte strobes
   input wire logic i_s_axi_wvalid,         // Write data valid
   output logic o_s_axi_wready,             // Write data ready
   output logic [1:0] o_s_axi_bresp,        // Write response
   output logic o_s_axi_bvalid,             // Write response valid
   input wire logic i_s_axi_bready,         // Write response ready
   input wire logic [7:0] i_s_axi_araddr,   // Read address
   input wire logic i_s_axi_arvalid,        // Read address valid
   output logic o_s_axi_arready,            // Read address ready
   output logic [31:0] o_s_axi_rdata,       // Read data
   output logic [1:0] o_s_axi_rresp,        // Read response
   output logic o_s_axi_rvalid,             // Read data valid
   input wire logic i_s_axi_rready,         // Read data ready
   input wire csf_acc_type i_acc,           // Accumulator status from core
   input wire logic i_loop_active,          // Loop in progress
   input wire csf_alu_type i_alu,           // ALU result update
   input wire logic i_nesting_disable,      // Nesting disable control
   input wire logic i_ipl_load,             // Core loads priority level
   input wire logic [2:0] i_ipl_value,      // Priority level to load
   output logic [15:0] o_cpu_status_word,   // Status word
   output logic [15:0] o_core_control_word, // Core control word
   output logic [3:0] o_cpu_priority_level, // Full priority level
   output logic o_irq                       // Event interrupt
);

   // ----------------------------------------------------------------
   // Bus front end
   // ----------------------------------------------------------------
   csf_wr_type wr;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_ok, wr_ok;

   csf_axil_slave u_bus (
      .i_clk           (i_clk),
      .i_rst_n         (i_rst_n),
      .i_s_axi_awaddr  (i_s_axi_awaddr),
      .i_s_axi_awvalid (i_s_axi_awvalid),
      .o_s_axi_awready (o_s_axi_awready),
      .i_s_axi_wdata   (i_s_axi_wdata),
      .i_s_axi_wstrb   (i_s_axi_wstrb),
      .i_s_axi_wvalid  (i_s_axi_wvalid),
      .o_s_axi_wready  (o_s_axi_wready),
      .o_s_axi_bresp   (o_s_axi_bresp),
      .o_s_axi_bvalid  (o_s_axi_bvalid),
      .i_s_axi_bready  (i_s_axi_bready),
      .i_s_axi_araddr  (i_s_axi_araddr),
      .i_s_axi_arvalid (i_s_axi_arvalid),
      .o_s_axi_arready (o_s_axi_arready),
      .o_s_axi_rdata   (o_s_axi_rdata),
      .o_s_axi_rresp   (o_s_axi_rresp),
      .o_s_axi_rvalid  (o_s_axi_rvalid),
      .i_s_axi_rready  (i_s_axi_rready),
      .o_wr            (wr),
      .i_wr_ok         (wr_ok),
      .o_rd_addr       (rd_addr),
      .i_rd_data       (rd_data),
      .i_rd_ok         (rd_ok)
   );

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   logic wr_sr, wr_core, wr_evt_stat, wr_evt_mask;
   logic [15:0] lane_mask;

   assign wr_sr = wr.fire && csf_hit(wr.addr, CSF_OFS_STATUS);
   assign wr_core = wr.fire && csf_hit(wr.addr, CSF_OFS_CORE_CTRL);
   assign wr_evt_stat = wr.fire && csf_hit(wr.addr, CSF_OFS_EVT_STAT);
   assign wr_evt_mask = wr.fire && csf_hit(wr.addr, CSF_OFS_EVT_MASK);
   assign wr_ok = csf_hit(wr.addr, CSF_OFS_STATUS) ||
                  csf_hit(wr.addr, CSF_OFS_CORE_CTRL) ||
                  csf_hit(wr.addr, CSF_OFS_EVT_STAT) ||
                  csf_hit(wr.addr, CSF_OFS_EVT_MASK);
   assign lane_mask = {{8{wr.strb[1]}}, {8{wr.strb[0]}}};

   // ----------------------------------------------------------------
   // Half carry
   // ----------------------------------------------------------------
   logic [4:0] nib_sum;
   logic [8:0] byte_sum;
   logic half_carry;

   always_comb begin
      nib_sum = {1'b0, i_alu.op_a[3:0]} + {1'b0, i_alu.op_b[3:0]} +
                {4'h0, i_alu.carry_in};
      byte_sum = {1'b0, i_alu.op_a[7:0]} + {1'b0, i_alu.op_b[7:0]} +
                 {8'h00, i_alu.carry_in};
      half_carry = i_alu.byte_op ? nib_sum[4] : byte_sum[8];
   end

   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   csf_sr_type sr_reg, sr_next;
   logic sat_clr_a, sat_clr_b;

   always_comb begin
      sr_next = sr_reg;
      sat_clr_a = 1'b0;
      sat_clr_b = 1'b0;
      // Overflow and loop flags mirror the core; software cannot write
      sr_next.ovf_a = i_acc.ovf_a;
      sr_next.ovf_b = i_acc.ovf_b;
      sr_next.loop = i_loop_active;
      if (wr_sr && wr.strb[1]) begin
         // Writing zero clears; a one never sets
         sat_clr_a = !wr.data[CSF_BIT_SAT_A] ||
                     !wr.data[CSF_BIT_SAT_AB];
         sat_clr_b = !wr.data[CSF_BIT_SAT_B] ||
                     !wr.data[CSF_BIT_SAT_AB];
         sr_next.dc = wr.data[CSF_BIT_DC];
      end
      if (wr_sr && wr.strb[0]) begin
         if (!i_nesting_disable) begin
            sr_next.ipl = wr.data[7:5];
         end
         sr_next.flags[3:0] = wr.data[3:0];
      end
      // Saturation set beats a software clear in the same cycle
      sr_next.sat_a = i_acc.sat_a || (sr_reg.sat_a && !sat_clr_a);
      sr_next.sat_b = i_acc.sat_b || (sr_reg.sat_b && !sat_clr_b);
      // Core updates win over a simultaneous bus write
      if (i_ipl_load) begin
         sr_next.ipl = i_ipl_value;
      end
      if (i_alu.valid) begin
         sr_next.dc = half_carry;
         sr_next.flags = i_alu.flags;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sr_reg <= CSF_SR_RESET;
      end else begin
         sr_reg <= sr_next;
      end
   end

   // ----------------------------------------------------------------
   // Core control word
   // ----------------------------------------------------------------
   logic [15:0] core_reg, core_next;

   always_comb begin
      core_next = core_reg;
      if (wr_core) begin
         core_next = ((wr.data[15:0] & lane_mask) |
                      (core_reg & ~lane_mask)) & CSF_CORE_IMPL;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         core_reg <= CSF_CORE_RESET;
      end else begin
         core_reg <= core_next;
      end
   end

   // ----------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------
   logic [CSF_EVT_N-1:0] evt, evt_stat, evt_mask;

   always_comb begin
      evt = '0;
      evt[CSF_EVT_OVF_A] = i_acc.ovf_a && !sr_reg.ovf_a;
      evt[CSF_EVT_OVF_B] = i_acc.ovf_b && !sr_reg.ovf_b;
      evt[CSF_EVT_SAT_A] = i_acc.sat_a && !sr_reg.sat_a;
      evt[CSF_EVT_SAT_B] = i_acc.sat_b && !sr_reg.sat_b;
   end

   csf_irq #(
      .N (CSF_EVT_N)
   ) u_irq (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_evt     (evt),
      .i_wr_stat (wr_evt_stat && wr.strb[0]),
      .i_wr_mask (wr_evt_mask && wr.strb[0]),
      .i_wdata   (wr.data[CSF_EVT_N-1:0]),
      .o_stat    (evt_stat),
      .o_mask    (evt_mask),
      .o_irq     (o_irq)
   );

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok = 1'b1;
      if (csf_hit(rd_addr, CSF_OFS_STATUS)) begin
         rd_data = {16'h0000, csf_sr_pack(sr_reg)};
      end else if (csf_hit(rd_addr, CSF_OFS_CORE_CTRL)) begin
         rd_data = {16'h0000, core_reg & CSF_CORE_IMPL};
      end else if (csf_hit(rd_addr, CSF_OFS_EVT_STAT)) begin
         rd_data = {28'h000_0000, evt_stat};
      end else if (csf_hit(rd_addr, CSF_OFS_EVT_MASK)) begin
         rd_data = {28'h000_0000, evt_mask};
      end else begin
         rd_ok = 1'b0;
      end
   end

   assign o_cpu_status_word = csf_sr_pack(sr_reg);
   assign o_core_control_word = core_reg;
   assign o_cpu_priority_level = {core_reg[CSF_BIT_IPL_MSB], sr_reg.ipl};

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_sr_hi_write;
      wr_sr && wr.strb[1];
   endsequence

   sequence s_pair_taken;
      i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid &&
      o_s_axi_wready && !o_s_axi_bvalid;
   endsequence

   a_ovf_follow: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      ##1 (o_cpu_status_word[CSF_BIT_OVF_A] == $past(i_acc.ovf_a)) &&
      (o_cpu_status_word[CSF_BIT_OVF_B] == $past(i_acc.ovf_b)))
      else $error("overflow flag does not follow accumulator");

   a_half_carry: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      i_alu.valid |=> o_cpu_status_word[CSF_BIT_DC] == $past(half_carry))
      else $error("half carry flag wrong after alu update");

   a_ipl_locked: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (wr_sr && wr.strb[0] && i_nesting_disable && !i_ipl_load)
      |=> $stable(o_cpu_priority_level[2:0]))
      else $error("priority bits changed while nesting disabled");

   a_unimpl_zero: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      o_s_axi_rvalid |-> (o_s_axi_rdata[31:16] == 16'h0000) &&
      (o_core_control_word[15:13] == 3'b000))
      else $error("unimplemented bits read nonzero");

   a_sat_sticky: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (o_cpu_status_word[CSF_BIT_SAT_A] && !(wr_sr && wr.strb[1]))
      |=> o_cpu_status_word[CSF_BIT_SAT_A])
      else $error("saturation flag dropped without a clear");

   a_sat_combined: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      s_sr_hi_write ##0 !wr.data[CSF_BIT_SAT_AB] ##0 !i_acc.sat_a ##0
      !i_acc.sat_b |=> !o_cpu_status_word[CSF_BIT_SAT_A] &&
      !o_cpu_status_word[CSF_BIT_SAT_B] &&
      !o_cpu_status_word[CSF_BIT_SAT_AB])
      else $error("combined clear left a saturation flag set");

   a_write_resp: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      s_pair_taken |=> ##1 o_s_axi_bvalid)
      else $error("write response not two cycles after address");

   a_irq_level: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (|(evt & evt_mask) && !wr_evt_mask) |=> o_irq)
      else $error("unmasked event did not raise the interrupt");

   a_sat_set: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      i_acc.sat_b |=> o_cpu_status_word[CSF_BIT_SAT_B] &&
      o_cpu_status_word[CSF_BIT_SAT_AB])
      else $error("saturation event did not set its flag");

   a_loop_mirror: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      ##1 o_cpu_status_word[CSF_BIT_LOOP] == $past(i_loop_active))
      else $error("loop flag does not follow the core");

   a_ipl_load: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      i_ipl_load |=> o_cpu_priority_level[2:0] == $past(i_ipl_value))
      else $error("core priority load not applied");

   a_read_answer: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_s_axi_arvalid && o_s_axi_arready) |=> o_s_axi_rvalid)
      else $error("read answer not one cycle after address");

endmodule : csf_status_top

// ===== tb_csf_status_top.sv
// Self-checking bench for the CPU status flag block
`timescale 1ns/10ps
module tb_csf_status_top
   import csf_pkg::*;
;
   logic clk = 0;
   logic rst_n = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   csf_acc_type acc = '0;
   csf_alu_type alu = '0;
   logic loop_act = 0, nd = 0;
   logic [15:0] sw, ccw, r;
   logic [3:0] pl;
   logic [33:0] exp_q[$];
   logic [1:0] exp_b[$];
   logic ipl_ld = 0;
   logic [2:0] ipl_v = 0;
   int failures = 0, samples_checked = 0, cycles = 0;
   logic [31:0] seed = 32'h0000_F25B;

   always #5 clk = ~clk;

   csf_status_top i_dut (.i_clk(clk), .i_rst_n(rst_n),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
      .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
      .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
      .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
      .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
      .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
      .i_s_axi_rready(rready), .i_acc(acc), .i_loop_active(loop_act),
      .i_alu(alu), .i_nesting_disable(nd), .i_ipl_load(ipl_ld),
      .i_ipl_value(ipl_v), .o_cpu_status_word(sw),
      .o_core_control_word(ccw), .o_cpu_priority_level(pl), .o_irq(irq));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic chk(input logic [33:0] got, input logic [33:0] e);
      samples_checked++;
      if (got !== e) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, e);
      end
   endtask : chk

   task automatic tally_and_finish();
      if (failures == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   // Master holds each channel until its own handshake edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d,
                     input logic [1:0] rs = CSF_RESP_OKAY);
      exp_b.push_back(rs);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [1:0] rs,
                     input logic [15:0] e);
      exp_q.push_back({rs, 16'h0000, e});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      @(posedge clk);
   endtask : rd

   task automatic opc(input logic b, input logic [15:0] a,
                      input logic [15:0] c, input logic ci, input logic dc);
      logic [31:0] v;
      logic [3:0] f;
      v = xs();
      f = v[3:0];
      alu <= {1'b1, b, a, c, ci, 1'b0, f};
      @(posedge clk);
      alu.valid <= 1'b0;
      rd(CSF_OFS_STATUS, CSF_RESP_OKAY, {7'h0, dc, 4'h0, f});
   endtask : opc

   always @(posedge clk) begin
      if (rvalid && rready && exp_q.size() != 0)
         chk({rresp, rdata}, exp_q.pop_front());
      if (bvalid && bready && exp_b.size() != 0)
         chk({32'h0, bresp}, {32'h0, exp_b.pop_front()});
      cycles++;
      if (cycles == 5000) begin
         failures++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(CSF_OFS_STATUS, CSF_RESP_OKAY, 16'h0000);
      rd(CSF_OFS_CORE_CTRL, CSF_RESP_OKAY, CSF_CORE_RESET);
      wr(CSF_OFS_EVT_MASK, 16'h0001);
      acc <= 4'b1000;
      loop_act <= 1'b1;
      @(posedge clk);
      wr(CSF_OFS_STATUS, 16'h0000);
      rd(CSF_OFS_STATUS, CSF_RESP_OKAY, 16'h8A00);
      chk({33'h0, irq}, 34'h1);
      acc <= 4'b0100;
      loop_act <= 1'b0;
      repeat (2) @(posedge clk);
      rd(CSF_OFS_STATUS, CSF_RESP_OKAY, 16'h4800);
      wr(CSF_OFS_EVT_STAT, 16'h0001);
      chk({33'h0, irq}, 34'h0);
      rd(CSF_OFS_EVT_STAT, CSF_RESP_OKAY, 16'h0002);
      acc <= 4'b0011;
      @(posedge clk);
      acc <= 4'b0000;
      repeat (2) @(posedge clk);
      rd(CSF_OFS_STATUS, CSF_RESP_OKAY, 16'h3400);
      wr(CSF_OFS_STATUS, 16'h1400);
      rd(CSF_OFS_STATUS, CSF_RESP_OKAY, 16'h1400);
      wr(CSF_OFS_STATUS, 16'h3000);
      rd(CSF_OFS_STATUS, CSF_RESP_OKAY, 16'h0000);
      opc(1'b1, 16'h000F, 16'h0001, 1'b0, 1'b1);
      opc(1'b1, 16'h00F0, 16'h0010, 1'b0, 1'b0);
      opc(1'b0, 16'h00F0, 16'h0010, 1'b0, 1'b1);
      opc(1'b1, 16'h000F, 16'h0000, 1'b1, 1'b1);
      opc(1'b0, 16'h0F0F, 16'h0000, 1'b1, 1'b0);
      nd <= 1'b1;
      wr(CSF_OFS_STATUS, 16'h00E0);
      rd(CSF_OFS_STATUS, CSF_RESP_OKAY, 16'h0000);
      ipl_ld <= 1'b1;
      ipl_v <= 3'h3;
      @(posedge clk);
      ipl_ld <= 1'b0;
      rd(CSF_OFS_STATUS, CSF_RESP_OKAY, 16'h0060);
      nd <= 1'b0;
      wr(CSF_OFS_STATUS, 16'h00E0);
      rd(CSF_OFS_STATUS, CSF_RESP_OKAY, 16'h00E0);
      chk({18'h0, sw}, 34'h00E0);
      wr(CSF_OFS_CORE_CTRL, 16'hFFFF);
      rd(CSF_OFS_CORE_CTRL, CSF_RESP_OKAY, 16'h1FFF);
      chk({30'h0, pl}, 34'hF);
      for (int i = 0; i < 4; i++) begin
         r = 16'(xs());
         wr(CSF_OFS_CORE_CTRL, r);
         rd(CSF_OFS_CORE_CTRL, CSF_RESP_OKAY, r & 16'h1FFF);
      end
      chk({18'h0, ccw}, {18'h0, r & CSF_CORE_IMPL});
      wr(8'h80, 16'hFFFF, CSF_RESP_SLVERR);
      rd(CSF_OFS_CORE_CTRL, CSF_RESP_OKAY, r & CSF_CORE_IMPL);
      rd(8'h80, CSF_RESP_SLVERR, 16'h0000);
      repeat (2) @(posedge clk);
      chk(34'(exp_q.size() + exp_b.size()), 34'h0);
      tally_and_finish();
   end
endmodule : tb_csf_status_top
